// ---- asc_ctrl.sv ----
// slot map, input format, restart delay and result queue/dma control
// Function
// RQ1: slots 12-19 hold 5-bit channels, four per word at bits 28:24..4:0.
// RQ2: a slot naming an unimplemented channel is ignored by the sequencer.
// RQ3: wait programmed conversion-clock periods before a continuous restart.
// RQ4: 32-bit format register, bit n sets input format of channel n.
// RQ5: software keeps the format register at its reset value.
// RQ6: all channels single-ended; a one bit means single-ended.
// RQ7: queue count above threshold raises dma request and level flag.
// RQ8: software programs threshold only from zero to sixteen.
// RQ9: 2-bit format selects pushed word: status, data only, raw.
// RQ10: writing one to flush empties the queue; flush reads zero.
// RQ11: dma enable gates the threshold dma request.
// RQ12: queue level reported from zero to sixteen.
// RQ13: empty-queue read or invalid channel returns word with invalid flag; data-only and raw words carry no invalid flag.
`timescale 1ns/1ps
module asc_ctrl #(
    parameter logic [31:0] IMPL_MASK = asc_pkg::FORMAT_RST,
    parameter int DEPTH = asc_pkg::QUEUE_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [2:0] slot_sel_i,
    output logic [4:0] slot_chan_o,
    output logic slot_valid_o,
    input wire logic cont_en_i,
    input wire logic seq_done_i,
    input wire logic conv_tick_i,
    output logic restart_o,
    output logic [31:0] chan_format_o,
    input wire logic smp_valid_i,
    input wire logic [4:0] smp_chan_i,
    input wire logic [17:0] smp_raw_i,
    input wire logic smp_clip_i,
    input wire logic dma_ack_i,
    output logic dma_req_o,
    output logic irq_o
);
    localparam int CW = $clog2(DEPTH) + 1;
    logic [4:0] slot_q [0:asc_pkg::NUM_SLOTS-1];
    logic [15:0] restart_q;
    logic [31:0] format_q, rdata_d, head;
    logic [7:0] thr_q;
    logic [1:0] qfmt_q;
    logic [asc_pkg::INT_W-1:0] int_stat_q, int_mask_q, int_evt;
    logic [CW-1:0] fifo_cnt;
    logic dma_en_q, fifo_full, fifo_empty, above, pop;
    logic wr_map_lo, wr_map_hi, wr_qctrl, flush, rd_data, rd_int;
    function automatic logic chan_ok(input logic [4:0] chan);
        chan_ok = IMPL_MASK[chan]; // RQ2
    endfunction : chan_ok
    function automatic logic above_thr(input logic [CW-1:0] cnt,
                                       input logic [7:0] thr);
        above_thr = {{(8-CW){1'b0}}, cnt} > thr;
    endfunction : above_thr
    function automatic logic [31:0] pack_map(input logic [4:0] f0,
        input logic [4:0] f1, input logic [4:0] f2, input logic [4:0] f3);
        pack_map = {3'b000, f3, 3'b000, f2, 3'b000, f1, 3'b000, f0}; // RQ1
    endfunction : pack_map
    // builds the queued word for the selected queue format
    function automatic logic [31:0] fmt_word(input logic [1:0] fmt,
        input logic [4:0] chan, input logic [17:0] raw, input logic clip);
        logic [31:0] w;
        logic [11:0] proc;
        w = '0;
        proc = raw[17:6];
        case (fmt)
            asc_pkg::QF_DATA_ONLY: w[11:0] = proc;
            asc_pkg::QF_RAW: w[17:0] = raw;
            // reserved code behaves as data plus status
            default:
            begin
                w[11:0] = proc;
                w[asc_pkg::CHAN_LSB +: 5] = chan;
                w[asc_pkg::INV_BIT] = !chan_ok(chan); // RQ13
                w[asc_pkg::CLIP_BIT] = clip;
            end
        endcase
        fmt_word = w; // RQ9
    endfunction : fmt_word
    assign wr_map_lo = reg_wr_i && reg_addr_i == asc_pkg::OFS_MAP_LO;
    assign wr_map_hi = reg_wr_i && reg_addr_i == asc_pkg::OFS_MAP_HI;
    assign wr_qctrl = reg_wr_i && reg_addr_i == asc_pkg::OFS_QCTRL;
    assign flush = wr_qctrl && reg_wdata_i[asc_pkg::FLUSH_BIT]; // RQ10
    assign rd_data = reg_rd_i && reg_addr_i == asc_pkg::OFS_DATA;
    assign rd_int = reg_rd_i && reg_addr_i == asc_pkg::OFS_INT_STAT;
    // a cpu read and a dma ack in one cycle consume a single word
    assign pop = rd_data || dma_ack_i;
    assign above = above_thr(fifo_cnt, thr_q);
    asc_result_fifo #(
        .WIDTH(32),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .push_i(smp_valid_i),
        .push_data_i(fmt_word(qfmt_q, smp_chan_i, smp_raw_i, smp_clip_i)),
        .pop_i(pop),
        .flush_i(flush),
        .head_o(head),
        .count_o(fifo_cnt),
        .full_o(fifo_full),
        .empty_o(fifo_empty)
    );
    asc_restart_timer #(
        .CW(asc_pkg::RESTART_W)
    ) u_restart (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .cont_en_i(cont_en_i),
        .seq_done_i(seq_done_i),
        .tick_i(conv_tick_i),
        .delay_i(restart_q),
        .restart_o(restart_o)
    );

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < asc_pkg::NUM_SLOTS; i++)
            begin
                slot_q[i] <= asc_pkg::MAP_RST[4:0];
            end
        end
        else
        begin
            for (int i = 0; i < asc_pkg::SLOTS_PER_REG; i++)
            begin
                if (wr_map_lo)
                begin
                    slot_q[i] <=
                        reg_wdata_i[i*asc_pkg::SLOT_STRIDE +: 5]; // RQ1
                end
                if (wr_map_hi)
                begin
                    slot_q[i+4] <=
                        reg_wdata_i[i*asc_pkg::SLOT_STRIDE +: 5]; // RQ1
                end
            end
        end
    end
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            restart_q <= asc_pkg::RESTART_RST;
            format_q <= asc_pkg::FORMAT_RST; // RQ6
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == asc_pkg::OFS_RESTART)
            begin
                restart_q <= reg_wdata_i[15:0]; // RQ3
            end
            // storage kept, but software is expected never to change it
            if (reg_addr_i == asc_pkg::OFS_FORMAT)
            begin
                format_q <= reg_wdata_i; // RQ4
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            thr_q <= '0;
            qfmt_q <= asc_pkg::QF_DATA_STATUS;
            dma_en_q <= 1'b0;
        end
        else if (wr_qctrl)
        begin
            thr_q <= reg_wdata_i[asc_pkg::THR_LSB +: asc_pkg::THR_W];
            qfmt_q <= reg_wdata_i[asc_pkg::QFMT_LSB +: 2]; // RQ9
            dma_en_q <= reg_wdata_i[asc_pkg::DMAEN_BIT];
        end
    end

    // each implemented channel input is single-ended when its format bit is one; unimplemented channels are forced to zero
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            chan_format_o <= asc_pkg::FORMAT_RST;
        end
        else
        begin
            chan_format_o <= format_q & IMPL_MASK; // RQ4
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            slot_chan_o <= '0;
            slot_valid_o <= 1'b0;
        end
        else
        begin
            slot_chan_o <= slot_q[slot_sel_i];
            slot_valid_o <= chan_ok(slot_q[slot_sel_i]); // RQ2
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            dma_req_o <= 1'b0;
        end
        else
        begin
            dma_req_o <= dma_en_q && above; // RQ7 RQ11
        end
    end

    assign int_evt[asc_pkg::IRQ_LVL] = above; // RQ7
    assign int_evt[asc_pkg::IRQ_OVF] = smp_valid_i && fifo_full && !flush;
    assign int_evt[asc_pkg::IRQ_UNF] = pop && fifo_empty;

    // read clears status; an event in the clearing cycle survives
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            int_stat_q <= '0;
            int_mask_q <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            int_stat_q <= (rd_int ? '0 : int_stat_q) | int_evt;
            irq_o <= |(((rd_int ? '0 : int_stat_q) | int_evt) & int_mask_q);
            if (reg_wr_i && reg_addr_i == asc_pkg::OFS_INT_MASK)
            begin
                int_mask_q <= reg_wdata_i[asc_pkg::INT_W-1:0];
            end
        end
    end

    always_comb
    begin
        rdata_d = '0;
        case (reg_addr_i)
            asc_pkg::OFS_MAP_LO:
                rdata_d = pack_map(slot_q[0], slot_q[1], slot_q[2], slot_q[3]);
            asc_pkg::OFS_MAP_HI:
                rdata_d = pack_map(slot_q[4], slot_q[5], slot_q[6], slot_q[7]);
            asc_pkg::OFS_RESTART: rdata_d[15:0] = restart_q;
            asc_pkg::OFS_FORMAT: rdata_d = format_q;
            asc_pkg::OFS_QCTRL:
            begin
                // flush has no storage and reads zero
                rdata_d[asc_pkg::THR_LSB +: asc_pkg::THR_W] = thr_q; // RQ10
                rdata_d[asc_pkg::QFMT_LSB +: 2] = qfmt_q;
                rdata_d[asc_pkg::DMAEN_BIT] = dma_en_q;
            end
            asc_pkg::OFS_DATA:
                rdata_d = fifo_empty ? asc_pkg::EMPTY_WORD : head; // RQ13
            asc_pkg::OFS_STATUS:
            begin
                rdata_d[asc_pkg::LVL_LSB +: CW] = fifo_cnt; // RQ12
                rdata_d[asc_pkg::FULL_BIT] = fifo_full;
                rdata_d[asc_pkg::EMPTY_BIT] = fifo_empty;
            end
            asc_pkg::OFS_INT_STAT: rdata_d[asc_pkg::INT_W-1:0] = int_stat_q;
            asc_pkg::OFS_INT_MASK: rdata_d[asc_pkg::INT_W-1:0] = int_mask_q;
            default: rdata_d = '0;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= '0;
        end
        else
        begin
            reg_rdata_o <= reg_rd_i ? rdata_d : '0;
        end
    end

    sequence s_rd_empty;
        rd_data && fifo_empty;
    endsequence
    sequence s_flush_then_idle;
        flush ##1 !smp_valid_i;
    endsequence
    chk_map_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_map_hi |=> slot_q[7] == $past(reg_wdata_i[28:24])
            && slot_q[4] == $past(reg_wdata_i[4:0])) // RQ1
        else $error("slot map write not stored in its field");
    chk_slot_invalid: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !IMPL_MASK[slot_q[slot_sel_i]] |=> !slot_valid_o) // RQ2
        else $error("unimplemented channel offered as valid slot");
    chk_format_rst: assert property (@(posedge clk_sys_i)
        rst_i |=> chan_format_o == asc_pkg::FORMAT_RST) // RQ6
        else $error("format outputs not single-ended after reset");
    chk_format_path: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        1'b1 |=> chan_format_o == ($past(format_q) & IMPL_MASK)) // RQ4
        else $error("format register does not steer channel format");
    chk_lvl_flag: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        above |=> int_stat_q[asc_pkg::IRQ_LVL]) // RQ7
        else $error("level flag not set above threshold");
    chk_dma_thresh: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (dma_en_q && above) |=> dma_req_o) // RQ7
        else $error("dma request missing above threshold");
    chk_dma_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        dma_req_o |-> $past(dma_en_q) && $past(above)) // RQ11
        else $error("dma request without enable or level");
    chk_push_raw: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (smp_valid_i && fifo_empty && qfmt_q == asc_pkg::QF_RAW && !flush)
            |=> head == {14'h0000, $past(smp_raw_i)}) // RQ9
        else $error("raw format word wrong");
    chk_flush_empty: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        s_flush_then_idle |-> fifo_cnt == '0 ##1 fifo_cnt == '0) // RQ10
        else $error("flush left words in the queue");
    chk_flush_read0: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (reg_rd_i && reg_addr_i == asc_pkg::OFS_QCTRL)
            |=> !reg_rdata_o[asc_pkg::FLUSH_BIT]) // RQ10
        else $error("flush bit read as one");
    chk_level_max: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fifo_cnt <= CW'(DEPTH)) // RQ12
        else $error("queue level above depth");
    chk_empty_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        s_rd_empty |=> reg_rdata_o == asc_pkg::EMPTY_WORD) // RQ13
        else $error("empty read lacks invalid flag");
endmodule : asc_ctrl

// ---- asc_pkg.sv ----
// constants, field layout and types shared by the converter slot/queue control
package asc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MAP_LO = 8'h1c;
    localparam logic [7:0] OFS_MAP_HI = 8'h20;
    localparam logic [7:0] OFS_RESTART = 8'h2c;
    localparam logic [7:0] OFS_FORMAT = 8'h3c;
    localparam logic [7:0] OFS_QCTRL = 8'h40;
    localparam logic [7:0] OFS_DATA = 8'h44;
    localparam logic [7:0] OFS_STATUS = 8'h48;
    localparam logic [7:0] OFS_INT_STAT = 8'h60;
    localparam logic [7:0] OFS_INT_MASK = 8'h64;
    // slot map: four 5-bit fields per word, one per byte lane
    localparam int SLOT_W = 5;
    localparam int SLOT_STRIDE = 8;
    localparam int SLOTS_PER_REG = 4;
    localparam int NUM_SLOTS = 8;
    // restart delay field
    localparam int RESTART_W = 16;
    // queue control fields
    localparam int THR_LSB = 8;
    localparam int THR_W = 8;
    localparam int QFMT_LSB = 2;
    localparam int FLUSH_BIT = 1;
    localparam int DMAEN_BIT = 0;
    // status fields
    localparam int LVL_LSB = 8;
    localparam int FULL_BIT = 2;
    localparam int EMPTY_BIT = 1;
    // result word fields
    localparam int CLIP_BIT = 31;
    localparam int INV_BIT = 24;
    localparam int CHAN_LSB = 16;
    localparam int PROC_W = 12;
    localparam int RAW_W = 18;
    // interrupt status bits
    localparam int INT_W = 3;
    localparam int IRQ_LVL = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_UNF = 2;
    // reset values
    localparam logic [31:0] MAP_RST = 32'h0000_0000;
    localparam logic [31:0] FORMAT_RST = 32'h0000_dfff;
    localparam logic [31:0] EMPTY_WORD = 32'h811f_ffff;
    localparam logic [15:0] RESTART_RST = 16'h0000;
    localparam int QUEUE_DEPTH = 16;

    typedef enum logic [1:0] {
        QF_DATA_STATUS = 2'b00,
        QF_DATA_ONLY = 2'b01,
        QF_RAW = 2'b10,
        QF_RSVD = 2'b11
    } asc_qfmt_t;

    typedef enum logic [0:0] {
        RT_IDLE = 1'b0,
        RT_WAIT = 1'b1
    } asc_rt_state_t;
endpackage : asc_pkg

// ---- asc_result_fifo.sv ----
// result queue storage with level count and flush
`timescale 1ns/1ps
module asc_result_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = asc_pkg::QUEUE_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic push_i,
    input wire logic [WIDTH-1:0] push_data_i,
    input wire logic pop_i,
    input wire logic flush_i,
    output logic [WIDTH-1:0] head_o,
    output logic [AW:0] count_o,
    output logic full_o,
    output logic empty_o
);
    // depth must be a power of two so the pointers wrap on their own
    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic do_push;
    logic do_pop;

    assign full_o = (count_q == (AW+1)'(DEPTH));
    assign empty_o = (count_q == '0);
    assign do_push = push_i && !full_o;
    assign do_pop = pop_i && !empty_o;
    assign head_o = mem_q[rd_ptr_q];
    assign count_o = count_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (do_push)
        begin
            mem_q[wr_ptr_q] <= push_data_i;
        end
    end

    // flush beats a push landing in the same cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i || flush_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end
        else
        begin
            if (do_push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (do_pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (do_push && !do_pop)
            begin
                count_q <= count_q + 1'b1;
            end
            else if (do_pop && !do_push)
            begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule : asc_result_fifo

// ---- asc_restart_timer.sv ----
// counts conversion-clock ticks before a continuous sequence restarts
`timescale 1ns/1ps
module asc_restart_timer #(
    parameter int CW = asc_pkg::RESTART_W
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic cont_en_i,
    input wire logic seq_done_i,
    input wire logic tick_i,
    input wire logic [CW-1:0] delay_i,
    output logic restart_o
);
    asc_pkg::asc_rt_state_t state_q;
    logic [CW-1:0] cnt_q;
    logic start;
    logic fire;

    assign start = (state_q == asc_pkg::RT_IDLE) && seq_done_i && cont_en_i;
    assign fire = (start && delay_i == '0)
        || (state_q == asc_pkg::RT_WAIT && cont_en_i && tick_i
            && cnt_q == CW'(1)); // RQ3

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            state_q <= asc_pkg::RT_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            case (state_q)
                asc_pkg::RT_IDLE:
                begin
                    if (start && delay_i != '0)
                    begin
                        state_q <= asc_pkg::RT_WAIT;
                        cnt_q <= delay_i; // RQ3
                    end
                end
                asc_pkg::RT_WAIT:
                begin
                    // leaving continuous mode abandons the pending restart
                    if (!cont_en_i || fire)
                    begin
                        state_q <= asc_pkg::RT_IDLE;
                    end
                    else if (tick_i)
                    begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default:
                begin
                    state_q <= asc_pkg::RT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            restart_o <= 1'b0;
        end
        else
        begin
            restart_o <= fire;
        end
    end

    chk_restart_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (start && delay_i == '0) |=> restart_o) // RQ3
        else $error("zero restart delay did not restart at once");
endmodule : asc_restart_timer

// ---- asc_dma_model.sv ----
// behavioural dma controller that drains the result queue on request
`timescale 1ns/1ps
module asc_dma_model (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic dma_req_i,
    input wire logic [3:0] gap_i,
    output logic dma_ack_o,
    output logic [7:0] taken_o
);
    logic ack_q;
    logic [7:0] taken_q;
    logic [3:0] wait_q;

    // request lags the level by a cycle, so a gap of at least 2 avoids
    // popping a word that has already gone
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            taken_q <= 8'h00;
            wait_q <= 4'h0;
        end
        else
        begin
            ack_q <= 1'b0;
            if (wait_q != 4'h0)
                wait_q <= wait_q - 4'h1;
            else if (enable_i && dma_req_i && !ack_q)
            begin
                ack_q <= 1'b1;
                taken_q <= taken_q + 8'h01;
                wait_q <= gap_i;
            end
        end
    end

    assign dma_ack_o = ack_q;
    assign taken_o = taken_q;
endmodule : asc_dma_model

// ---- tb.sv ----
// self-checking testbench for the slot map and result queue control
`timescale 1ns/1ps
module tb;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_s = 1'b0, rd_s = 1'b0, seq = 1'b0, tick = 1'b0, cont = 1'b0;
    logic smp = 1'b0, clip = 1'b0, dma_on = 1'b0, ack, req, irq, rst_o;
    logic [2:0] sel = 3'h0;
    logic [4:0] chan = 5'h00, slot_chan;
    logic [17:0] raw = 18'h0_0000;
    logic [31:0] rdata, fmt_o, v;
    logic [3:0] gap = 4'h3;
    logic [7:0] taken;
    logic slot_valid;
    int errors = 0;
    int checks_done = 0;

    asc_ctrl u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .slot_sel_i(sel), .slot_chan_o(slot_chan),
        .slot_valid_o(slot_valid), .cont_en_i(cont), .seq_done_i(seq),
        .conv_tick_i(tick), .restart_o(rst_o), .chan_format_o(fmt_o),
        .smp_valid_i(smp), .smp_chan_i(chan), .smp_raw_i(raw),
        .smp_clip_i(clip), .dma_ack_i(ack), .dma_req_o(req), .irq_o(irq));

    asc_dma_model u_dma (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .enable_i(dma_on), .dma_req_i(req), .gap_i(gap), .dma_ack_o(ack),
        .taken_o(taken));

    initial
    begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task results;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_sys_i);
        wr_s <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_sys_i);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask : rdc

    task push(input logic [4:0] c, input logic [17:0] r, input logic k);
        @(posedge clk_sys_i);
        smp <= 1'b1;
        chan <= c;
        raw <= r;
        clip <= k;
        @(posedge clk_sys_i);
        smp <= 1'b0;
    endtask : push

    // pulse one input for a cycle, then look at the following cycle
    task pulse(input int which);
        @(posedge clk_sys_i);
        if (which == 0) seq <= 1'b1; else tick <= 1'b1;
        @(posedge clk_sys_i);
        seq <= 1'b0;
        tick <= 1'b0;
        #1;
    endtask : pulse

    function automatic logic [31:0] word(input int f, input logic [4:0] c,
                                         input logic [17:0] r, input logic k);
        logic inv;
        inv = ~asc_pkg::FORMAT_RST[c];
        case (f)
            1: word = {20'h0_0000, r[17:6]};
            2: word = {14'h0000, r};
            default: word = {k, 6'h00, inv, 3'h0, c, 4'h0, r[17:6]};
        endcase
    endfunction : word

    task t_reset;
        rdc(asc_pkg::OFS_MAP_LO, 32'h0000_0000);
        rdc(asc_pkg::OFS_MAP_HI, 32'h0000_0000);
        rdc(asc_pkg::OFS_RESTART, 32'h0000_0000);
        rdc(asc_pkg::OFS_FORMAT, 32'h0000_dfff);
        chk(fmt_o, 32'h0000_dfff);
        rdc(asc_pkg::OFS_QCTRL, 32'h0000_0000);
        rdc(asc_pkg::OFS_STATUS, 32'h0000_0002);
        rdc(8'h80, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_slots;
        logic [4:0] ch [8] = '{5'h01, 5'h0d, 5'h02, 5'h14,
                               5'h03, 5'h0e, 5'h05, 5'h00};
        wr(asc_pkg::OFS_MAP_LO, 32'hffff_ffff);
        rdc(asc_pkg::OFS_MAP_LO, 32'h1f1f_1f1f);
        wr(asc_pkg::OFS_MAP_LO, 32'h1402_0d01);
        wr(asc_pkg::OFS_MAP_HI, 32'h0005_0e03);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_sys_i);
            sel <= i[2:0];
            @(posedge clk_sys_i);
            #1 chk({27'h0, slot_chan}, {27'h0, ch[i]});
            chk(32'(slot_valid), 32'(asc_pkg::FORMAT_RST[ch[i]]));
        end
        $display("test slots done");
    endtask : t_slots

    task t_restart;
        wr(asc_pkg::OFS_RESTART, 32'h0000_0002);
        cont <= 1'b1;
        pulse(0);
        chk({31'h0, rst_o}, 32'h0000_0000);
        pulse(1);
        chk({31'h0, rst_o}, 32'h0000_0000);
        pulse(1);
        chk({31'h0, rst_o}, 32'h0000_0001);
        wr(asc_pkg::OFS_RESTART, 32'h0000_0000);
        pulse(0);
        chk({31'h0, rst_o}, 32'h0000_0001);
        @(posedge clk_sys_i);
        cont <= 1'b0;
        $display("test restart done");
    endtask : t_restart

    task t_formats;
        wr(asc_pkg::OFS_INT_MASK, 32'h0000_0001);
        for (int f = 0; f < 3; f++)
        begin
            wr(asc_pkg::OFS_QCTRL, 32'h0000_0200 | (f << 2));
            push(5'd1, 18'h2_abc0, 1'b0);
            push(5'd13, 18'h1_5a7f, 1'b1);
            rdc(asc_pkg::OFS_DATA, word(f, 5'd1, 18'h2_abc0, 1'b0));
            rdc(asc_pkg::OFS_DATA, word(f, 5'd13, 18'h1_5a7f, 1'b1));
        end
        for (int i = 0; i < 3; i++) push(5'd2, 18'h0_0040, 1'b0);
        rdc(asc_pkg::OFS_STATUS, 32'h0000_0300);
        chk({31'h0, irq}, 32'h0000_0001);
        chk({31'h0, req}, 32'h0000_0000);
        wr(asc_pkg::OFS_QCTRL, 32'h0000_0202);
        rdc(asc_pkg::OFS_STATUS, 32'h0000_0002);
        rdc(asc_pkg::OFS_QCTRL, 32'h0000_0200);
        rd(asc_pkg::OFS_INT_STAT, v);
        rdc(asc_pkg::OFS_INT_STAT, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        rdc(asc_pkg::OFS_DATA, asc_pkg::EMPTY_WORD);
        $display("test formats done");
    endtask : t_formats

    task t_dma;
        int n;
        wr(asc_pkg::OFS_INT_MASK, 32'h0000_0002);
        rd(asc_pkg::OFS_INT_STAT, v);
        wr(asc_pkg::OFS_QCTRL, 32'h0000_0000);
        for (int i = 0; i < 17; i++) push(i[4:0], {i[5:0], 12'h000}, 1'b0);
        rdc(asc_pkg::OFS_STATUS, 32'h0000_1004);
        chk({31'h0, irq}, 32'h0000_0001);
        chk({31'h0, req}, 32'h0000_0000);
        rdc(asc_pkg::OFS_INT_STAT, 32'h0000_0003);
        repeat (2) @(posedge clk_sys_i);
        #1 chk({31'h0, irq}, 32'h0000_0000);
        // dma stalls three cycles between words while the queue drains
        dma_on <= 1'b1;
        wr(asc_pkg::OFS_QCTRL, 32'h0000_0001);
        @(posedge clk_sys_i);
        #1 chk({31'h0, req}, 32'h0000_0001);
        n = 0;
        while (taken < 8'd16 && n < 500)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        repeat (4) @(posedge clk_sys_i);
        #1 chk({24'h0, taken}, 32'h0000_0010);
        chk({31'h0, req}, 32'h0000_0000);
        rdc(asc_pkg::OFS_STATUS, 32'h0000_0002);
        dma_on <= 1'b0;
        $display("test dma done");
    endtask : t_dma

    initial
    begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        // software never writes the format register, it keeps its reset
        t_reset();
        t_slots();
        t_restart();
        t_formats();
        t_dma();
        results();
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        errors++;
        results();
    end
endmodule : tb
